// File: src/qsf_pkg.sv
// Constants of the serial flash front end: opcodes, address map, timing.
// Assumes a 50 MHz core clock; the serial clock comes from the host.
package qsf_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ    = 50000;
  localparam int SW_RST_US  = 30;
  localparam int SW_RST_CYC = SW_RST_US * CLK_KHZ / 1000;
  localparam int HW_RST_NS  = 1000;
  localparam int HW_RST_CYC = (HW_RST_NS * CLK_KHZ + 999999) / 1000000;

  // ----------------------------------------------------------------
  // Address organisation
  // ----------------------------------------------------------------
  localparam int PAGE_BYTES = 256;
  localparam int ADDR_BITS  = 24;
  localparam int ADDR_MSB   = 21;
  localparam int SECT_LSB   = 12;
  localparam int BLK_LSB    = 16;
  localparam int HBLK_LSB   = 15;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ   = 8'h03;
  localparam logic [7:0] OP_FREAD  = 8'h0b;
  localparam logic [7:0] OP_DOUT   = 8'h3b;
  localparam logic [7:0] OP_DIO    = 8'hbb;
  localparam logic [7:0] OP_QOUT   = 8'h6b;
  localparam logic [7:0] OP_QIO    = 8'heb;
  localparam logic [7:0] OP_RDST   = 8'h05;
  localparam logic [7:0] OP_WEN    = 8'h06;
  localparam logic [7:0] OP_WDIS   = 8'h04;
  localparam logic [7:0] OP_STW    = 8'h01;
  localparam logic [7:0] OP_PP     = 8'h02;
  localparam logic [7:0] OP_SE     = 8'h20;
  localparam logic [7:0] OP_BE32   = 8'h52;
  localparam logic [7:0] OP_BE64   = 8'hd8;
  localparam logic [7:0] OP_CE_A   = 8'h60;
  localparam logic [7:0] OP_CE_B   = 8'hc7;
  localparam logic [7:0] OP_SUS_A  = 8'h75;
  localparam logic [7:0] OP_SUS_B  = 8'hb0;
  localparam logic [7:0] OP_RES_A  = 8'h7a;
  localparam logic [7:0] OP_RES_B  = 8'h30;
  localparam logic [7:0] OP_RARM   = 8'h66;
  localparam logic [7:0] OP_RST    = 8'h99;
  localparam logic [7:0] OP_QON    = 8'h38;
  localparam logic [7:0] OP_QOFF   = 8'hff;

  // ----------------------------------------------------------------
  // Link phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_CMD  = 3'h0,
    PH_ADDR = 3'h1,
    PH_DUMY = 3'h2,
    PH_DATA = 3'h3,
    PH_TAIL = 3'h4,
    PH_IGN  = 3'h5
  } qsf_ph_t;

endpackage

// File: src/qsf_front_end.sv
// Serial front end of a 32-Mbit flash: link shifter on the host clock,
// command decision, mode, write latch, resets and pause on the core clock.
// Assumes the host keeps rd_byte, quad_lane_enable and pause_reset_sel
// steady through a frame, and the array engine reports op_busy.
//
// Behaviour
// (R1) Array is 256-byte pages, 4K sectors, 32K/64K blocks; sector/block/chip erase.
// (R2) Unknown command: standby, output off, ignore bus until chip select rises.
// (R3) Known command keeps the device active until chip select rises.
// (R4) Sample on rising serial clock, drive on falling; modes 0 and 3.
// (R5) Reads may end after any output bit without error.
// (R6) Write-type commands run only if chip select rises on a byte boundary.
// (R7) Array access during status write, program or erase is ignored.
// (R8) Dual reads move two bits a clock on lanes 0 and 1.
// (R9) Quad reads use four lanes, guard and pause pins as lanes 2, 3.
// (R10) Quad commands only run with quad enable set.
// (R11) 38h enters four-wire command mode, FFh leaves; one mode at a time.
// (R12) Four-wire command mode takes opcodes on all four lanes.
// (R13) Power-up and software reset start in plain SPI mode.
// (R14) Four-wire command mode only with quad enable set.
// (R15) Software reset needs 66h then 99h back to back.
// (R16) After software reset, refuse commands for 30 us.
// (R17) Config bit picks shared pin: 0 pause, 1 active-low reset.
// (R18) Reset pin low 1 us aborts operations, restores power-on state.
// (R19) Quad enable disables pause and reset on the shared pin.
// (R20) Pause on pin fall, resume on rise, each once serial clock is low.
// (R21) Pause leaves internal operations running.
// (R22) While paused, output off and clock and input ignored.
// (R23) Chip select rising during pause resets the interface.
// (R24) Address bits 21:12 pick the sector, 21:16 the block.
// (R25) Data-changing commands need the write enable latch set.
`timescale 1ns/10ps
module qsf_front_end
  import qsf_pkg::*;
(
  // Core clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Serial link
  input  wire logic       sclk,
  input  wire logic       cs_b,
  input  wire logic [3:0] io_in,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe_b,
  // Configuration and array side
  input  wire logic       quad_lane_enable,
  input  wire logic       pause_reset_sel,
  input  wire logic       op_busy,
  input  wire logic [7:0] rd_byte,
  // Status and commands
  output logic            four_wire_command_mode,
  output logic            write_enable_latch,
  output logic            reset_busy,
  output logic            paused,
  output logic            cmd_stb,
  output logic      [7:0] cmd_code,
  output logic     [23:0] cmd_addr,
  output logic      [9:0] cmd_sector,
  output logic      [5:0] cmd_block,
  output logic            cmd_refused,
  output logic            hw_abort
);

  // ----------------------------------------------------------------
  // Lane helpers
  // ----------------------------------------------------------------
  function automatic logic known(input logic [7:0] o, input logic q);
    case (o)
      OP_READ, OP_FREAD, OP_DOUT, OP_DIO, OP_RDST, OP_WEN, OP_WDIS,
      OP_STW, OP_PP, OP_SE, OP_BE32, OP_BE64, OP_CE_A, OP_CE_B,
      OP_SUS_A, OP_SUS_B, OP_RES_A, OP_RES_B, OP_RARM, OP_RST,
      OP_QOFF: known = 1'b1;
      OP_QOUT, OP_QIO, OP_QON: known = q; // R10 R14
      default: known = 1'b0;
    endcase
  endfunction

  function automatic logic is_read(input logic [7:0] o);
    is_read = (o == OP_READ) || (o == OP_FREAD) || (o == OP_DOUT) ||
              (o == OP_DIO) || (o == OP_QOUT) || (o == OP_QIO);
  endfunction

  function automatic logic [2:0] dwid(input logic [7:0] o,
                                      input logic m);
    if (m || o == OP_QOUT || o == OP_QIO) dwid = 3'h4; // R9
    else if (o == OP_DOUT || o == OP_DIO) dwid = 3'h2; // R8
    else dwid = 3'h1;
  endfunction

  function automatic logic [2:0] awid(input logic [7:0] o,
                                      input logic m);
    if (m || o == OP_QIO) awid = 3'h4;
    else if (o == OP_DIO) awid = 3'h2;
    else awid = 3'h1;
  endfunction

  function automatic logic [7:0] sh8(input logic [7:0] v,
                                     input logic [2:0] w,
                                     input logic [3:0] d);
    case (w)
      3'h4:    sh8 = {v[3:0], d};
      3'h2:    sh8 = {v[5:0], d[1:0]};
      default: sh8 = {v[6:0], d[0]};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Link domain: crossings in and frame start
  // ----------------------------------------------------------------
  logic    qe_l1_r, qe_l_r, md_l_r, pz_l1_r, pz_l_r;
  logic    fresh_r;
  logic    mode_r, paused_r;

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      qe_l1_r <= 1'b0;
      qe_l_r  <= 1'b0;
      pz_l1_r <= 1'b0;
      pz_l_r  <= 1'b0;
    end else begin
      qe_l1_r <= quad_lane_enable;
      qe_l_r  <= qe_l1_r;
      pz_l1_r <= paused_r;
      pz_l_r  <= pz_l1_r;
    end
  end

  // Set while chip select is high; first rising edge starts a frame
  always_ff @(posedge sclk or posedge cs_b or negedge rst_b) begin
    if (!rst_b)    fresh_r <= 1'b1;
    else if (cs_b) fresh_r <= 1'b1; // R2 R23
    else           fresh_r <= 1'b0;
  end

  // Mode is steady between frames; a frame must see it from its first bit
  always_ff @(negedge cs_b or negedge rst_b) begin
    if (!rst_b) md_l_r <= 1'b0;
    else        md_l_r <= mode_r; // R12
  end

  // ----------------------------------------------------------------
  // Link domain: shifter
  // ----------------------------------------------------------------
  qsf_ph_t     ph_r, ph_nxt, ph_b;
  logic  [4:0] bits_r, bits_nxt, bits_b;
  logic  [2:0] tot_r, tot_nxt, tot_b;
  logic  [7:0] op_r, op_nxt, op_b;
  logic [23:0] ad_r, ad_nxt;
  logic  [7:0] dsr_r, dsr_nxt;
  logic        tgl_r, tgl_nxt;
  logic  [2:0] cw, aw, dw;

  always_comb begin
    ph_b     = fresh_r ? PH_CMD : ph_r;
    bits_b   = fresh_r ? 5'h00 : bits_r;
    tot_b    = fresh_r ? 3'h0 : tot_r;
    op_b     = fresh_r ? 8'h00 : op_r;
    cw       = md_l_r ? 3'h4 : 3'h1; // R12
    aw       = awid(op_b, md_l_r);
    dw       = dwid(op_b, md_l_r);
    ph_nxt   = ph_b;
    bits_nxt = bits_b;
    tot_nxt  = tot_b;
    op_nxt   = op_b;
    ad_nxt   = ad_r;
    dsr_nxt  = dsr_r;
    tgl_nxt  = tgl_r;
    if (!pz_l_r) begin // R22
      tot_nxt = tot_b + cw; // R6
      unique case (ph_b)
        PH_CMD: begin
          op_nxt   = sh8(op_b, cw, io_in); // R4
          bits_nxt = bits_b + 5'(cw);
          if (bits_nxt == 5'd8) begin
            tgl_nxt  = ~tgl_r;
            bits_nxt = 5'h00;
            if (!known(op_nxt, qe_l_r)) ph_nxt = PH_IGN; // R2
            else if (is_read(op_nxt)) ph_nxt = PH_ADDR; // R3
            else if (op_nxt == OP_RDST) begin
              ph_nxt  = PH_DATA;
              dsr_nxt = rd_byte;
            end else ph_nxt = PH_TAIL;
          end
        end
        PH_ADDR: begin
          ad_nxt   = {ad_r[19:0], 4'h0};
          ad_nxt   = (aw == 3'h4) ? {ad_r[19:0], io_in} :
                     (aw == 3'h2) ? {ad_r[21:0], io_in[1:0]} :
                                    {ad_r[22:0], io_in[0]};
          bits_nxt = bits_b + 5'(aw);
          if (bits_nxt == 5'(ADDR_BITS)) begin
            bits_nxt = 5'h00;
            if (op_b == OP_READ) begin
              ph_nxt  = PH_DATA;
              dsr_nxt = rd_byte;
            end else ph_nxt = PH_DUMY;
          end
        end
        PH_DUMY: begin
          bits_nxt = bits_b + 5'(aw);
          if (bits_nxt == 5'd8) begin
            bits_nxt = 5'h00;
            ph_nxt   = PH_DATA;
            dsr_nxt  = rd_byte;
          end
        end
        PH_DATA: begin // R5
          dsr_nxt  = sh8(dsr_r, dw, 4'h0);
          bits_nxt = bits_b + 5'(dw);
          if (bits_nxt == 5'd8) begin
            bits_nxt = 5'h00;
            dsr_nxt  = rd_byte;
          end
        end
        PH_TAIL: begin
          // Erase and program take their address; later bits are dropped
          if (bits_b != 5'(ADDR_BITS)) begin
            ad_nxt   = (aw == 3'h4) ? {ad_r[19:0], io_in} :
                       (aw == 3'h2) ? {ad_r[21:0], io_in[1:0]} :
                                      {ad_r[22:0], io_in[0]};
            bits_nxt = bits_b + 5'(aw);
          end
        end
        PH_IGN:  ph_nxt = PH_IGN;
      endcase
    end
  end

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      ph_r   <= PH_IGN;
      bits_r <= 5'h00;
      tot_r  <= 3'h0;
      op_r   <= 8'h00;
      ad_r   <= 24'h000000;
      dsr_r  <= 8'h00;
      tgl_r  <= 1'b0;
    end else begin
      ph_r   <= ph_nxt;
      bits_r <= bits_nxt;
      tot_r  <= tot_nxt;
      op_r   <= op_nxt;
      ad_r   <= ad_nxt;
      dsr_r  <= dsr_nxt;
      tgl_r  <= tgl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: output drive on falling edges
  // ----------------------------------------------------------------
  logic [3:0] out_nxt, oe_nxt;

  always_comb begin
    out_nxt = 4'h0;
    oe_nxt  = 4'hf;
    unique case (dwid(op_r, md_l_r))
      3'h4:    out_nxt = dsr_r[7:4];
      3'h2:    out_nxt = {2'h0, dsr_r[7:6]};
      default: out_nxt = {2'h0, dsr_r[7], 1'b0};
    endcase
    if (ph_r == PH_DATA && !fresh_r && !pz_l_r) begin // R4 R22
      unique case (dwid(op_r, md_l_r))
        3'h4:    oe_nxt = 4'h0; // R9
        3'h2:    oe_nxt = 4'hc; // R8
        default: oe_nxt = 4'hd;
      endcase
    end
  end

  always_ff @(negedge sclk or posedge cs_b or negedge rst_b) begin
    if (!rst_b) begin
      io_out  <= 4'h0;
      io_oe_b <= 4'hf;
    end else if (cs_b) begin
      io_out  <= 4'h0;
      io_oe_b <= 4'hf; // R2 R5
    end else begin
      io_out  <= out_nxt;
      io_oe_b <= oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: pin synchronisers
  // ----------------------------------------------------------------
  logic cs_1, cs_s, cs_q, sk_1, sk_s, pn_1, pn_s, tg_1, tg_s;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_1 <= 1'b1;
      cs_s <= 1'b1;
      cs_q <= 1'b1;
      sk_1 <= 1'b0;
      sk_s <= 1'b0;
      pn_1 <= 1'b1;
      pn_s <= 1'b1;
      tg_1 <= 1'b0;
      tg_s <= 1'b0;
    end else begin
      cs_1 <= cs_b;
      cs_s <= cs_1;
      cs_q <= cs_s;
      sk_1 <= sclk;
      sk_s <= sk_1;
      pn_1 <= io_in[3];
      pn_s <= pn_1;
      tg_1 <= tgl_r;
      tg_s <= tg_1;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: command decision, resets, pause
  // ----------------------------------------------------------------
  logic        wel_r, wel_nxt, arm_r, arm_nxt, mode_nxt, pz_nxt;
  logic        tsn_r, tsn_nxt, stb_nxt, ref_nxt, abt_nxt;
  logic [10:0] swc_r, swc_nxt;
  logic  [6:0] hwc_r, hwc_nxt;
  logic  [7:0] code_nxt;
  logic [23:0] addr_nxt;
  logic        frame_end, new_cmd, aligned, hw_low, chg, hold_ok;

  always_comb begin
    frame_end = cs_s && !cs_q;
    new_cmd   = tg_s != tsn_r;
    aligned   = tot_r == 3'h0;
    hw_low    = pause_reset_sel && !quad_lane_enable && !pn_s; // R17 R19
    hold_ok   = !pause_reset_sel && !quad_lane_enable; // R19
    chg       = (op_r == OP_STW) || (op_r == OP_PP) || (op_r == OP_SE) ||
                (op_r == OP_BE32) || (op_r == OP_BE64) ||
                (op_r == OP_CE_A) || (op_r == OP_CE_B);
    mode_nxt  = mode_r;
    wel_nxt   = wel_r;
    arm_nxt   = arm_r;
    tsn_nxt   = frame_end ? tg_s : tsn_r;
    swc_nxt   = (swc_r != 11'h000) ? swc_r - 11'h001 : swc_r;
    hwc_nxt   = 7'h00;
    stb_nxt   = 1'b0;
    ref_nxt   = 1'b0;
    abt_nxt   = 1'b0;
    code_nxt  = cmd_code;
    addr_nxt  = cmd_addr;
    // Pause only with chip select low; changes from the pin wait for clock low
    pz_nxt    = paused_r;
    if (cs_s || !hold_ok) pz_nxt = 1'b0; // R23
    else if (!sk_s) pz_nxt = !pn_s; // R20 R21
    if (hw_low) begin // R18
      hwc_nxt = (hwc_r == 7'(HW_RST_CYC)) ? hwc_r : hwc_r + 7'h01;
      if (hwc_r == 7'(HW_RST_CYC - 1)) begin
        abt_nxt  = 1'b1;
        mode_nxt = 1'b0;
        wel_nxt  = 1'b0;
        arm_nxt  = 1'b0;
        swc_nxt  = 11'h000;
      end
    end else if (frame_end && new_cmd && swc_r == 11'h000) begin // R16
      arm_nxt = 1'b0;
      case (op_r)
        OP_WEN:  if (aligned) wel_nxt = 1'b1; // R6
        OP_WDIS: if (aligned) wel_nxt = 1'b0;
        OP_RARM: arm_nxt = aligned; // R15
        OP_RST: begin
          if (aligned && arm_r) begin // R15
            mode_nxt = 1'b0; // R13
            wel_nxt  = 1'b0;
            swc_nxt  = 11'(SW_RST_CYC); // R16
          end
        end
        OP_QON:  if (quad_lane_enable) mode_nxt = 1'b1; // R11 R14
        OP_QOFF: mode_nxt = 1'b0; // R11
        OP_SUS_A, OP_SUS_B, OP_RES_A, OP_RES_B: begin
          if (aligned) begin
            stb_nxt  = 1'b1;
            code_nxt = op_r;
          end
        end
        default: begin
          if (chg && aligned) begin // R6
            if (op_busy || !wel_r) ref_nxt = 1'b1; // R7 R25
            else begin
              stb_nxt  = 1'b1; // R1
              code_nxt = op_r;
              addr_nxt = ad_r;
              wel_nxt  = 1'b0;
            end
          end else if (is_read(op_r) && op_busy) ref_nxt = 1'b1; // R7
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r      <= 1'b0; // R13
      wel_r       <= 1'b0;
      arm_r       <= 1'b0;
      tsn_r       <= 1'b0;
      swc_r       <= 11'h000;
      hwc_r       <= 7'h00;
      paused_r    <= 1'b0;
      cmd_stb     <= 1'b0;
      cmd_refused <= 1'b0;
      hw_abort    <= 1'b0;
      cmd_code    <= 8'h00;
      cmd_addr    <= 24'h000000;
      cmd_sector  <= 10'h000;
      cmd_block   <= 6'h00;
    end else begin
      mode_r      <= mode_nxt;
      wel_r       <= wel_nxt;
      arm_r       <= arm_nxt;
      tsn_r       <= tsn_nxt;
      swc_r       <= swc_nxt;
      hwc_r       <= hwc_nxt;
      paused_r    <= pz_nxt;
      cmd_stb     <= stb_nxt;
      cmd_refused <= ref_nxt;
      hw_abort    <= abt_nxt;
      cmd_code    <= code_nxt;
      cmd_addr    <= addr_nxt;
      cmd_sector  <= addr_nxt[ADDR_MSB:SECT_LSB]; // R24
      cmd_block   <= addr_nxt[ADDR_MSB:BLK_LSB]; // R24
    end
  end

  assign four_wire_command_mode = mode_r;
  assign write_enable_latch     = wel_r;
  assign paused                 = paused_r;

  // reset_busy is its own flop so the output stays registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) reset_busy <= 1'b0;
    else        reset_busy <= (swc_nxt != 11'h000);
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_wel_gate: assert property ( // R25
    cmd_stb && (cmd_code == OP_PP || cmd_code == OP_SE ||
                cmd_code == OP_BE32 || cmd_code == OP_BE64 ||
                cmd_code == OP_STW || cmd_code == OP_CE_A ||
                cmd_code == OP_CE_B) |-> $past(wel_r, 1) && !wel_r)
    else $error("program issued without write enable latch");
  a_busy_refuse: assert property ( // R7
    frame_end && new_cmd && chg && aligned && op_busy && !hw_low &&
    swc_r == 11'h000 |=> cmd_refused && !cmd_stb)
    else $error("array access not refused while busy");
  a_unaligned_drop: assert property ( // R6
    frame_end && new_cmd && !aligned |=> !cmd_stb)
    else $error("unaligned write-type command executed");
  a_sw_reset: assert property ( // R13
    frame_end && new_cmd && op_r == OP_RST && arm_r && aligned &&
    !hw_low && swc_r == 11'h000 |=> !mode_r ##1 reset_busy [*8])
    else $error("software reset did not restore plain mode");
  a_reset_quiet: assert property ( // R16
    reset_busy |-> !cmd_stb && !cmd_refused)
    else $error("command taken during software reset");
  a_mode_qe: assert property ( // R14
    $rose(mode_r) |-> $past(quad_lane_enable, 1))
    else $error("four-wire mode entered without quad enable");
  a_hw_abort: assert property ( // R18
    hw_abort |-> !mode_r && !wel_r && $past(hw_low, 1))
    else $error("hardware reset left state behind");
  a_pause_edge: assert property ( // R20
    $rose(paused_r) |-> $past(!sk_s && !pn_s && !cs_s, 1))
    else $error("pause entered with clock high");
  a_pause_cs: assert property ( // R23
    cs_s |=> !paused_r)
    else $error("pause kept after chip select rose");
  a_sector_map: assert property ( // R24
    cmd_stb |-> cmd_sector == cmd_addr[ADDR_MSB:SECT_LSB] &&
                cmd_block == cmd_addr[ADDR_MSB:BLK_LSB])
    else $error("sector or block index wrong");
  a_standby_hiz: assert property ( // R2
    @(negedge sclk) disable iff (cs_b)
    ph_r == PH_IGN |=> io_oe_b == 4'hf)
    else $error("output driven in standby");

  c_erase: cover property (cmd_stb && cmd_code == OP_SE);
  c_refuse: cover property (cmd_refused);
  c_swreset: cover property ($rose(reset_busy));
  c_pause: cover property ($rose(paused_r) ##[1:50] $fell(paused_r));

endmodule

// File: verification/qsf_host_model.sv
// Host controller model: drives chip select, serial clock and lanes.
// Assumes mode 0 timing; the serial clock stands still between frames.
`timescale 1ns/10ps
module qsf_host_model (
  // Serial link
  sclk,
  cs_b,
  io_in,
  io_out,
  io_oe_b
);
  output logic       sclk;
  output logic       cs_b;
  output logic [3:0] io_in;
  input  wire  [3:0] io_out;
  input  wire  [3:0] io_oe_b;

  logic [3:0]  drv;
  logic [31:0] rx;
  logic [3:0]  oe_acc;

  initial begin
    sclk   = 1'b0;
    cs_b   = 1'b1;
    drv    = 4'he;
    rx     = 32'h0;
    oe_acc = 4'hf;
  end

  // Each lane shows the device drive when enabled, else the host value
  assign io_in = (~io_oe_b & io_out) | (io_oe_b & drv);

  // ----------------------------------------------------------------
  // Frame: n bits on four lanes if w is 4, else on lane 0, MSB first, then rd clocks of read data
  // ----------------------------------------------------------------
  task automatic frame(input logic [63:0] bits, input int n, input int w,
                       input int rd);
    logic p3;
    p3     = drv[3];
    oe_acc = 4'hf;
    cs_b   = 1'b0;
    for (int i = 0; i < n; i += w) begin
      if (w == 4)
        drv = bits[63-i -: 4];
      else
        drv[0] = bits[63-i];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    for (int k = 0; k < rd; k++) begin
      #15 sclk = 1'b1;
      rx     = {rx[30:0], io_out[1]};
      oe_acc = oe_acc & io_oe_b;
      #15 sclk = 1'b0;
    end
    #15 cs_b = 1'b1;
    drv[2:0] = ~drv[2:0];
    drv[3]   = p3;
  endtask
endmodule

// File: verification/test_quad_serial_flash_front_end.sv
// Self-checking bench for the serial flash front end.
// Assumes the host model owns the link; config pins set at clk fall.
`timescale 1ns/10ps
module test_quad_serial_flash_front_end;
  import qsf_pkg::*;

  logic        clk;
  logic        rst_b;
  logic        sclk;
  logic        cs_b;
  logic [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  io_oe_b;
  logic        qle;
  logic        prs;
  logic        op_busy;
  logic [7:0]  rd_byte;
  logic        mode;
  logic        latch;
  logic        rbusy;
  logic        paused;
  logic        cmd_stb;
  logic [7:0]  cmd_code;
  logic [23:0] cmd_addr;
  logic [9:0]  cmd_sector;
  logic [5:0]  cmd_block;
  logic        cmd_refused;
  logic        hw_abort;
  int          miscompares;
  int          n_tests;
  int          n_stb;
  int          n_ref;
  int          n_abt;
  int          s0;
  logic [7:0]  code_q;
  logic [23:0] addr_q;
  logic [9:0]  sec_q;
  logic [5:0]  blk_q;

  qsf_host_model host (.sclk(sclk), .cs_b(cs_b), .io_in(io_in),
                       .io_out(io_out), .io_oe_b(io_oe_b));

  qsf_front_end DUT (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
    .io_in(io_in), .io_out(io_out), .io_oe_b(io_oe_b),
    .quad_lane_enable(qle), .pause_reset_sel(prs), .op_busy(op_busy),
    .rd_byte(rd_byte), .four_wire_command_mode(mode),
    .write_enable_latch(latch), .reset_busy(rbusy), .paused(paused),
    .cmd_stb(cmd_stb), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
    .cmd_sector(cmd_sector), .cmd_block(cmd_block),
    .cmd_refused(cmd_refused), .hw_abort(hw_abort));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // Count the one-cycle pulses and keep what came with a strobe
  always @(negedge clk) begin
    if (cmd_stb === 1'b1) begin
      n_stb++;
      code_q = cmd_code;
      addr_q = cmd_addr;
      sec_q  = cmd_sector;
      blk_q  = cmd_block;
    end
    if (cmd_refused === 1'b1)
      n_ref++;
    if (hw_abort === 1'b1)
      n_abt++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] op, input int w);
    host.frame({op, 56'h0}, 8, w, 0);
    repeat (10) @(negedge clk);
  endtask

  task automatic summarize;
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_erase;
    cmd(OP_WEN, 1);
    chk("latch set", 32'h1, latch);
    s0 = n_stb;
    host.frame({OP_SE, 24'h2ab123, 32'h0}, 32, 1, 0);
    repeat (10) @(negedge clk);
    chk("strobes", 32'h1, n_stb - s0);
    chk("code", 32'h20, code_q);
    chk("addr", 32'h2ab123, addr_q);
    chk("sector", 32'h2ab, sec_q);
    chk("block", 32'h2a, blk_q);
    s0 = n_ref;
    host.frame({OP_BE64, 24'h010000, 32'h0}, 32, 1, 0);
    repeat (10) @(negedge clk);
    chk("refused", 32'h1, n_ref - s0);
  endtask

  task automatic t_align_busy;
    host.frame({OP_WEN, 56'h0}, 9, 1, 0);
    repeat (10) @(negedge clk);
    chk("odd frame latch", 32'h0, latch);
    cmd(OP_WEN, 1);
    op_busy = 1'b1;
    s0 = n_stb;
    host.frame({OP_PP, 24'h000100, 32'h0}, 32, 1, 0);
    repeat (10) @(negedge clk);
    chk("busy strobes", 32'h0, n_stb - s0);
    op_busy = 1'b0;
  endtask

  task automatic t_read;
    rd_byte = 8'ha6;
    host.frame({OP_READ, 24'h000100, 32'h0}, 32, 1, 12);
    chk("read bits", 32'ha6a, host.rx[11:0]);
    chk("read drive", 32'h0, host.oe_acc[1]);
    repeat (10) @(negedge clk);
    chk("idle oe", 32'hf, io_oe_b);
    host.frame({OP_QOUT, 24'h0, 32'h0}, 40, 1, 8);
    chk("unknown oe", 32'hf, host.oe_acc);
    repeat (10) @(negedge clk);
  endtask

  task automatic t_modes;
    qle = 1'b1;
    cmd(OP_QON, 1);
    chk("four wire on", 32'h1, mode);
    cmd(OP_QOFF, 4);
    chk("four wire off", 32'h0, mode);
    cmd(OP_QON, 1);
    cmd(OP_RARM, 4);
    cmd(OP_RST, 4);
    chk("reset busy", 32'h1, rbusy);
    cmd(OP_WEN, 1);
    chk("latch in reset", 32'h0, latch);
    for (int i = 0; i < 1600 && rbusy !== 1'b0; i++)
      @(negedge clk);
    chk("reset done", 32'h0, rbusy);
    chk("mode after reset", 32'h0, mode);
    qle = 1'b0;
  endtask

  task automatic t_hw_reset;
    cmd(OP_WEN, 1);
    prs = 1'b1;
    s0 = n_abt;
    host.drv[3] = 1'b0;
    repeat (60) @(negedge clk);
    chk("abort pulses", 32'h1, n_abt - s0);
    chk("latch after abort", 32'h0, latch);
    host.drv[3] = 1'b1;
    repeat (5) @(negedge clk);
    prs = 1'b0;
  endtask

  task automatic t_pause;
    host.cs_b   = 1'b0;
    host.drv[3] = 1'b0;
    repeat (5) @(negedge clk);
    chk("paused", 32'h1, paused);
    host.drv[3] = 1'b1;
    repeat (5) @(negedge clk);
    chk("resumed", 32'h0, paused);
    host.drv[3] = 1'b0;
    repeat (5) @(negedge clk);
    host.cs_b = 1'b1;
    repeat (5) @(negedge clk);
    chk("pause after deselect", 32'h0, paused);
    host.drv[3] = 1'b1;
    repeat (5) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_b       = 1'b1;
    qle         = 1'b0;
    prs         = 1'b0;
    op_busy     = 1'b0;
    rd_byte     = 8'h00;
    miscompares = 0;
    n_tests     = 0;
    n_stb       = 0;
    n_ref       = 0;
    n_abt       = 0;
    #1;
    rst_b = 1'b0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    t_erase();
    t_align_busy();
    t_read();
    t_modes();
    t_hw_reset();
    t_pause();
    summarize();
  end

  initial begin
    #500000;
    miscompares++;
    summarize();
  end
endmodule
